// [logic/amc_pkg.sv]
package amc_pkg;
  // Geometry
  localparam int NCH        = 16;
  localparam int DW         = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W      = 24;

  // Timing
  localparam int CLK_NS       = 8;
  localparam int TICK_NS      = 200;
  localparam int PRESC        = TICK_NS / CLK_NS;
  localparam int MAX_SPS      = 100000;
  localparam int MAX_SPS_PAIR = 200000;
  localparam int LAT_MAX_NS   = 20000;
  localparam int LAT_MAX_CYC  = LAT_MAX_NS / CLK_NS;
  localparam int CONV_NS      = 10000;
  localparam int CONV_CYC     = CONV_NS / CLK_NS;
  localparam int SETTLE_NS    = 1000000;
  localparam int SETTLE_CYC   = SETTLE_NS / CLK_NS;
  localparam logic [13:0] RATE_DIV_MIN      = 14'(1000000000 / (MAX_SPS * TICK_NS) - 1);
  localparam logic [13:0] RATE_DIV_MIN_PAIR = 14'(1000000000 / (MAX_SPS_PAIR * TICK_NS) - 1);

  // Operating modes
  localparam logic [2:0] MODE_IDLE  = 3'h0;
  localparam logic [2:0] MODE_BURST = 3'h1;
  localparam logic [2:0] MODE_CONT  = 3'h2;
  localparam logic [2:0] MODE_CAL   = 3'h3;
  localparam logic [2:0] MODE_TEST  = 3'h4;

  // Sample clock sources
  localparam logic [1:0] SRC_INT  = 2'h0;
  localparam logic [1:0] SRC_SOFT = 2'h1;
  localparam logic [1:0] SRC_EXT  = 2'h2;

  // Input selector codes
  localparam logic [2:0] BIT_FIELD = 3'h0;
  localparam logic [2:0] BIT_POS10 = 3'h1;
  localparam logic [2:0] BIT_NEG10 = 3'h2;
  localparam logic [2:0] BIT_POS5  = 3'h3;
  localparam logic [2:0] BIT_NEG5  = 3'h4;
  localparam logic [2:0] BIT_ZERO  = 3'h5;

  // Buffer size, channel groups, correction arithmetic
  localparam logic [4:0]  BSIZE_MAX    = 5'h16;
  localparam logic [15:0] CH_ALL       = 16'hFFFF;
  localparam logic [15:0] CH_LO        = 16'h00FF;
  localparam logic [15:0] CH_HI        = 16'hFF00;
  localparam int          GAIN_FRAC    = 14;
  localparam logic [15:0] GAIN_ONE     = 16'h4000;
  localparam logic [32:0] CAL_DIVIDEND = 33'h0_1FEF_8000;
  localparam logic [15:0] SAT_MAX      = 16'h7FFF;
  localparam logic [15:0] SAT_MIN      = 16'h8000;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RUN, ST_CAL_SETTLE, ST_CAL_PULSE, ST_CAL_CONV, ST_CAL_DIV, ST_CAL_OFS
  } amc_state_t;
endpackage

// [logic/amc_acq_ctrl.sv]
`timescale 1ns/1ps

module amc_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  // Clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_nrst,
  // Fill side
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  // Drain side
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wr;
    logic [AW-1:0]       rd;
    logic [AW:0]         cnt;
  } amc_fifo_st_t;

  amc_fifo_st_t s;
  amc_fifo_st_t next_s;
  logic         push;
  logic         pop;

  assign o_in_ready  = (s.cnt != (AW+1)'(D));
  assign o_out_valid = (s.cnt != '0);
  assign o_out_data  = s.mem[s.rd];

  always_comb begin
    next_s = s;
    push   = i_in_valid && o_in_ready;
    pop    = o_out_valid && i_out_ready;
    if (push) begin
      next_s.mem[s.wr] = i_in_data;
      next_s.wr        = s.wr + 1'b1;
    end
    if (pop) begin
      next_s.rd = s.rd + 1'b1;
    end
    next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

module amc_acq_ctrl #(
  parameter int SETTLE_CYC = amc_pkg::SETTLE_CYC
) (
  // Clock and reset
  input  wire logic                                        i_clock,
  input  wire logic                                        i_nrst,
  // Configuration, taken on i_cfg_wr
  input  wire logic                                        i_cfg_wr,
  input  wire logic [2:0]                                  i_mode,
  input  wire logic [1:0]                                  i_clk_src,
  input  wire logic                                        i_ext_rise,
  input  wire logic                                        i_pair,
  input  wire logic [4:0]                                  i_buf_size,
  input  wire logic [amc_pkg::NCH-1:0]                     i_chan_en,
  input  wire logic [13:0]                                 i_rate_div,
  input  wire logic [2:0]                                  i_bit_sel,
  input  wire logic                                        i_range_10v,
  // Indicator and sample triggers
  input  wire logic                                        i_led_wr,
  input  wire logic                                        i_led_on,
  input  wire logic                                        i_soft_sample,
  input  wire logic                                        i_ext_clk,
  // Converters
  input  wire logic [amc_pkg::NCH-1:0][amc_pkg::DW-1:0]    i_adc_data,
  output logic      [amc_pkg::NCH-1:0]                     o_sample,
  output logic      [2:0]                                  o_bit_sel,
  output logic                                             o_range_10v,
  // Status
  output logic                                             o_led,
  output logic      [2:0]                                  o_mode,
  output logic                                             o_cfg_err,
  output logic                                             o_buf_full,
  output logic                                             o_cal_done,
  // Host read port
  input  wire logic [63:0]                                 i_am_en,
  input  wire logic                                        i_rd_req,
  input  wire logic [5:0]                                  i_rd_am,
  output logic                                             o_rd_ack,
  output logic                                             o_rd_err,
  output logic      [amc_pkg::DW-1:0]                      o_rd_data
);
  import amc_pkg::*;

  typedef struct packed {
    amc_state_t             st;
    logic [2:0]             mode;
    logic [1:0]             src;
    logic                   erise;
    logic                   pair;
    logic [4:0]             bsize;
    logic [NCH-1:0]         en;
    logic [13:0]            rdiv;
    logic [2:0]             bsel;
    logic                   rng;
    logic                   led;
    logic                   cfg_err;
    logic [2:0]             ext_sync;
    logic                   ext_lvl;
    logic [4:0]             pre;
    logic [13:0]            rcnt;
    logic                   half;
    logic [NCH-1:0]         pend;
    logic [NCH-1:0]         wmask;
    logic [3:0]             ch;
    logic [NCH-1:0][DW-1:0] raw;
    logic [NCH-1:0][DW-1:0] zero;
    logic [NCH-1:0][DW-1:0] gain;
    logic [NCH-1:0][DW-1:0] ofs;
    logic [22:0]            cnt;
    logic                   full;
    logic [CNT_W-1:0]       wcnt;
    logic                   phase;
    logic                   npulse;
    logic [32:0]            rem;
    logic [15:0]            q;
    logic [3:0]             bit_i;
    logic [NCH-1:0]         sample;
    logic [2:0]             obit;
    logic                   cal_done;
    logic                   rd_ack;
    logic                   rd_err;
    logic [DW-1:0]          rd_data;
  } amc_acq_t;

  amc_acq_t          s;
  amc_acq_t          next_s;
  logic              fifo_in_valid;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic [DW-1:0]     fifo_out_data;
  logic              rd_pop;
  logic [DW-1:0]     corr;
  logic              pcnt;
  logic              tick;
  logic              ext_edge;
  logic [NCH-1:0]    grp;
  logic [NCH-1:0]    m;
  logic [3:0]        low;
  logic signed [32:0] prod;
  logic signed [19:0] sum;
  logic signed [16:0] span;
  logic [32:0]       trial;
  logic [15:0]       qn;
  logic [22:0]       depth;
  logic [4:0]        bs_eff;

  amc_fifo #(.W(DW), .D(FIFO_DEPTH)) u_buf (
    .i_clock     (i_clock),
    .i_nrst      (i_nrst),
    .i_in_valid  (fifo_in_valid),
    .i_in_data   (corr),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (fifo_out_valid),
    .o_out_data  (fifo_out_data),
    .i_out_ready (rd_pop)
  );

  assign rd_pop        = i_rd_req && i_am_en[i_rd_am] && fifo_out_valid;
  assign fifo_in_valid = (s.st == ST_RUN) && (s.wmask != '0) && !s.full;

  // Correction datapath, also used to derive offsets during calibration
  always_comb begin
    low = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (s.wmask[i]) begin
        low = 4'(i);
      end
    end
    prod = $signed(s.st == ST_CAL_OFS ? s.zero[s.ch] : s.raw[low])
         * $signed({1'b0, s.gain[s.st == ST_CAL_OFS ? s.ch : low]});
    sum  = 20'($signed(prod[32:GAIN_FRAC])) + 20'($signed(s.st == ST_CAL_OFS ? 16'h0000 : s.ofs[low]));
    corr = sum[15:0];
    if (sum[19:15] != {5{sum[19]}}) begin
      corr = sum[19] ? SAT_MIN : SAT_MAX;
    end
  end

  always_comb begin
    next_s        = s;
    next_s.sample = '0;
    next_s.rd_ack = 1'b0;
    next_s.rd_err = 1'b0;
    tick          = 1'b0;
    grp           = CH_ALL;
    m             = '0;
    pcnt          = '0;
    span          = 17'($signed(s.raw[s.ch])) - 17'($signed(s.zero[s.ch]));
    trial         = 33'(span) << s.bit_i;
    qn            = s.q;
    bs_eff        = (s.bsize > BSIZE_MAX) ? BSIZE_MAX : s.bsize;
    depth         = 23'h1 << bs_eff;

    // Pin sampler: a level counts once the last two stages agree
    next_s.ext_sync = {s.ext_sync[1:0], i_ext_clk};
    if (s.ext_sync[1] == s.ext_sync[2]) begin
      next_s.ext_lvl = s.ext_sync[2];
    end
    ext_edge = (next_s.ext_lvl != s.ext_lvl) && (next_s.ext_lvl == s.erise);

    if (i_led_wr) begin
      next_s.led = i_led_on;
    end

    // Host read: answer one cycle after the request
    if (i_rd_req) begin
      next_s.rd_ack  = rd_pop;
      next_s.rd_err  = !rd_pop;
      next_s.rd_data = rd_pop ? fifo_out_data : '0;
    end

    // Internal timer: prescaled tick, then rate divider
    if (s.st == ST_RUN) begin
      next_s.pre = s.pre + 1'b1;
      if (s.pre == 5'(PRESC - 1)) begin
        next_s.pre  = '0;
        next_s.rcnt = s.rcnt + 1'b1;
        if (s.rcnt >= s.rdiv) begin
          next_s.rcnt = '0;
          pcnt        = 1'b1;
        end
      end
    end
    case (s.src)
      SRC_INT:  tick = pcnt;
      SRC_SOFT: tick = i_soft_sample;
      SRC_EXT:  tick = ext_edge;
      default:  tick = 1'b0;
    endcase

    case (s.st)
      ST_IDLE: begin
        next_s.obit = s.bsel;
      end
      ST_RUN: begin
        next_s.obit = (s.mode == MODE_TEST) ? s.bsel : BIT_FIELD;
        if (s.pair) begin
          grp = s.half ? CH_HI : CH_LO;
        end
        if (tick && s.wmask == '0) begin
          m             = grp & s.en;
          next_s.sample = m;
          next_s.half   = s.pair ? !s.half : 1'b0;
          for (int i = 0; i < NCH; i++) begin
            if (m[i] && s.pend[i]) begin
              next_s.raw[i] = i_adc_data[i];
            end
          end
          next_s.wmask = m & s.pend;
          next_s.pend  = (s.pend & ~grp) | m;
        end else if (s.wmask != '0) begin
          if (s.full) begin
            next_s.wmask = '0;
          end else if (fifo_in_ready) begin
            next_s.wmask[low] = 1'b0;
            if (s.mode == MODE_BURST) begin
              next_s.cnt  = s.cnt + 1'b1;
              next_s.full = (s.cnt + 1'b1 == depth);
            end
          end
        end
      end
      ST_CAL_SETTLE: begin
        next_s.wcnt = s.wcnt - 1'b1;
        if (s.wcnt == '0) begin
          next_s.st = ST_CAL_PULSE;
        end
      end
      ST_CAL_PULSE: begin
        next_s.sample = CH_ALL;
        if (!s.npulse) begin
          next_s.npulse = 1'b1;
          next_s.wcnt   = CNT_W'(CONV_CYC - 1);
          next_s.st     = ST_CAL_CONV;
        end else if (!s.phase) begin
          next_s.raw    = i_adc_data;
          next_s.phase  = 1'b1;
          next_s.npulse = 1'b0;
          next_s.obit   = BIT_ZERO;
          next_s.wcnt   = CNT_W'(SETTLE_CYC - 1);
          next_s.st     = ST_CAL_SETTLE;
        end else begin
          next_s.zero  = i_adc_data;
          next_s.ch    = '0;
          next_s.rem   = CAL_DIVIDEND;
          next_s.q     = '0;
          next_s.bit_i = 4'hF;
          next_s.st    = ST_CAL_DIV;
        end
      end
      ST_CAL_CONV: begin
        next_s.wcnt = s.wcnt - 1'b1;
        if (s.wcnt == '0) begin
          next_s.st = ST_CAL_PULSE;
        end
      end
      ST_CAL_DIV: begin
        if (trial <= s.rem) begin
          next_s.rem  = s.rem - trial;
          qn          = s.q | (16'h0001 << s.bit_i);
        end
        next_s.q     = qn;
        next_s.bit_i = s.bit_i - 1'b1;
        if (s.bit_i == '0) begin
          next_s.gain[s.ch] = (span > 17'sh0_0000) ? qn : GAIN_ONE;
          next_s.st         = ST_CAL_OFS;
        end
      end
      ST_CAL_OFS: begin
        next_s.ofs[s.ch] = 16'h0000 - corr;
        next_s.ch        = s.ch + 1'b1;
        next_s.rem       = CAL_DIVIDEND;
        next_s.q         = '0;
        next_s.bit_i     = 4'hF;
        next_s.st        = ST_CAL_DIV;
        if (s.ch == 4'(NCH - 1)) begin
          next_s.cal_done = 1'b1;
          next_s.mode     = MODE_IDLE;
          next_s.obit     = s.bsel;
          next_s.st       = ST_IDLE;
        end
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase

    // Configuration write; a bad channel pattern is refused whole
    if (i_cfg_wr) begin
      next_s.cfg_err = !(i_chan_en inside {16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0010, 16'h0020,
                         16'h0040, 16'h0080, 16'h0100, 16'h0200, 16'h0400, 16'h0800, 16'h1000,
                         16'h2000, 16'h4000, 16'h8000} || $countones(i_chan_en) inside {2, 4, 8, 16});
      if (!next_s.cfg_err) begin
        next_s.mode     = i_mode;
        next_s.src      = i_clk_src;
        next_s.erise    = i_ext_rise;
        next_s.pair     = i_pair;
        next_s.bsize    = i_buf_size;
        next_s.en       = i_chan_en;
        next_s.bsel     = i_bit_sel;
        next_s.rng      = i_range_10v;
        next_s.rdiv     = i_rate_div;
        if (i_rate_div < (i_pair ? RATE_DIV_MIN_PAIR : RATE_DIV_MIN)) begin
          next_s.rdiv = i_pair ? RATE_DIV_MIN_PAIR : RATE_DIV_MIN;
        end
        // A calibration ending in this very cycle keeps its done flag
        next_s.cal_done = next_s.cal_done && !s.cal_done;
        next_s.pre      = '0;
        next_s.rcnt     = '0;
        next_s.half     = 1'b0;
        next_s.pend     = '0;
        next_s.wmask    = '0;
        next_s.cnt      = '0;
        next_s.full     = 1'b0;
        next_s.obit     = i_bit_sel;
        case (i_mode)
          MODE_BURST, MODE_CONT, MODE_TEST: begin
            next_s.st = ST_RUN;
          end
          MODE_CAL: begin
            next_s.st     = ST_CAL_SETTLE;
            next_s.phase  = 1'b0;
            next_s.npulse = 1'b0;
            next_s.obit   = i_range_10v ? BIT_POS10 : BIT_POS5;
            next_s.wcnt   = CNT_W'(SETTLE_CYC - 1);
          end
          default: begin
            next_s.mode = MODE_IDLE;
            next_s.st   = ST_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      s       <= '0;
      s.st    <= ST_IDLE;
      s.mode  <= MODE_IDLE;
      s.src   <= SRC_INT;
      s.bsize <= BSIZE_MAX;
      s.en    <= CH_ALL;
      s.rdiv  <= RATE_DIV_MIN;
      s.rng   <= 1'b1;
      s.erise <= 1'b1;
      s.led   <= 1'b1;
      s.gain  <= {NCH{GAIN_ONE}};
    end else begin
      s <= next_s;
    end
  end

  assign o_sample    = s.sample;
  assign o_bit_sel   = s.obit;
  assign o_range_10v = s.rng;
  assign o_led       = s.led;
  assign o_mode      = s.mode;
  assign o_cfg_err   = s.cfg_err;
  assign o_buf_full  = s.full;
  assign o_cal_done  = s.cal_done;
  assign o_rd_ack    = s.rd_ack;
  assign o_rd_err    = s.rd_err;
  assign o_rd_data   = s.rd_data;
endmodule

// [testbench/amc_acq_checker.sv]
`timescale 1ns/1ps
module amc_acq_checker (
  // Clock, reset and configuration
  input wire logic                     i_clock,
  input wire logic                     i_nrst,
  input wire logic                     i_cfg_wr,
  input wire logic [2:0]               i_mode,
  input wire logic [amc_pkg::NCH-1:0]  i_chan_en,
  input wire logic                     i_range_10v,
  input wire logic                     i_led_wr,
  input wire logic                     i_led_on,
  // Host read port
  input wire logic [63:0]              i_am_en,
  input wire logic                     i_rd_req,
  input wire logic [5:0]               i_rd_am,
  input wire logic                     o_rd_ack,
  input wire logic                     o_rd_err,
  input wire logic [amc_pkg::DW-1:0]   o_rd_data,
  // Status and converter controls
  input wire logic [amc_pkg::NCH-1:0]  o_sample,
  input wire logic [2:0]               o_bit_sel,
  input wire logic                     o_range_10v,
  input wire logic                     o_led,
  input wire logic [2:0]               o_mode,
  input wire logic                     o_cfg_err,
  input wire logic                     o_cal_done
);
  import amc_pkg::*;
  logic ok_en;
  assign ok_en = $countones(i_chan_en) inside {1, 2, 4, 8, 16};
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  a_read_answer: assert property (i_rd_req |=> o_rd_ack != o_rd_err)
    else $error("read request not answered exactly once");
  a_answer_cause: assert property ((o_rd_ack || o_rd_err) |-> $past(i_rd_req))
    else $error("read answer without request");
  a_modifier_refused: assert property (i_rd_req && !i_am_en[i_rd_am] |=> o_rd_err && o_rd_data == '0)
    else $error("disabled modifier code not refused");
  a_reset_state: assert property ($rose(i_nrst) |-> o_mode == MODE_IDLE && o_led && o_sample == '0)
    else $error("wrong state after reset");
  a_idle_quiet: assert property (o_mode == MODE_IDLE && $past(o_mode) == MODE_IDLE |-> o_sample == '0)
    else $error("sample pulse in idle mode");
  a_cfg_refused: assert property (i_cfg_wr && !ok_en |=> o_cfg_err && $stable(o_mode))
    else $error("bad channel group accepted");
  a_cfg_taken: assert property (i_cfg_wr && ok_en && i_mode <= MODE_TEST |=>
    !o_cfg_err && o_mode == $past(i_mode) && o_range_10v == $past(i_range_10v))
    else $error("valid configuration not taken");
  a_trim_reference: assert property (i_cfg_wr && ok_en && i_mode == MODE_CAL |=>
    o_bit_sel == ($past(i_range_10v) ? BIT_POS10 : BIT_POS5))
    else $error("self-trim did not route reference");
  a_cal_on_command: assert property ($rose(o_cal_done) |-> $past(o_mode) == MODE_CAL)
    else $error("calibration ended without command");
  a_led_write: assert property (i_led_wr |=> o_led == $past(i_led_on))
    else $error("indicator write lost");
endmodule

bind amc_acq_ctrl amc_acq_checker amc_acq_checker_i (.i_clock, .i_nrst, .i_cfg_wr, .i_mode, .i_chan_en,
  .i_range_10v, .i_led_wr, .i_led_on, .i_am_en, .i_rd_req, .i_rd_am, .o_rd_ack, .o_rd_err, .o_rd_data,
  .o_sample, .o_bit_sel, .o_range_10v, .o_led, .o_mode, .o_cfg_err, .o_cal_done);

// [testbench/amc_adc_model.sv]
`timescale 1ns/1ps
module amc_adc_model #(
  parameter logic [15:0] POS_CODE  = 16'h4000,
  parameter logic [15:0] ZERO_CODE = 16'h0020
) (
  // Clock and reset
  input  wire logic                                   i_clock,
  input  wire logic                                   i_nrst,
  // Converter controls
  input  wire logic [amc_pkg::NCH-1:0]                i_sample,
  input  wire logic [2:0]                             i_bit_sel,
  // Results
  output logic      [amc_pkg::NCH-1:0][amc_pkg::DW-1:0] o_data
);
  import amc_pkg::*;
  logic [NCH-1:0][DW-1:0] result;
  logic [NCH-1:0][10:0]   busy;
  logic [11:0]            seq;

  function automatic logic [15:0] level(input int ch);
    case (i_bit_sel)
      BIT_FIELD: level = {4'(ch), seq};
      BIT_POS10, BIT_POS5: level = POS_CODE;
      BIT_NEG10, BIT_NEG5: level = -POS_CODE;
      default: level = ZERO_CODE;
    endcase
  endfunction

  // Each channel holds and converts on its own pulse
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      result <= '0;
      busy <= {NCH{11'(CONV_CYC)}};
      seq <= '0;
    end else begin
      if (|i_sample) seq <= seq + 12'h1;
      for (int ch = 0; ch < NCH; ch++) begin
        if (i_sample[ch]) begin
          busy[ch] <= 11'(CONV_CYC - 4);
          result[ch] <= level(ch);
        end else if (busy[ch] != '0) begin
          busy[ch] <= busy[ch] - 11'h1;
        end
      end
    end
  end

  // An unfinished conversion shows a pattern that moves every cycle
  always_comb begin
    for (int ch = 0; ch < NCH; ch++) begin
      o_data[ch] = result[ch] ^ {16{busy[ch] != '0 && busy[ch][0]}} ^ {8{busy[ch] != '0, 1'b0}};
    end
  end
endmodule

// [testbench/tb_amc_acq_ctrl.sv]
`timescale 1ns/1ps
module tb_amc_acq_ctrl;
  import amc_pkg::*;
  localparam logic [15:0] POS = 16'h4000;
  localparam logic [15:0] ZERO = 16'h0020;
  logic i_clock, i_nrst, i_cfg_wr, i_ext_rise, i_pair, i_range_10v, i_led_wr, i_led_on, i_soft_sample;
  logic i_ext_clk, i_rd_req, o_range_10v, o_led, o_cfg_err, o_buf_full, o_cal_done, o_rd_ack, o_rd_err;
  logic [2:0] i_mode, i_bit_sel, o_bit_sel, o_mode;
  logic [1:0] i_clk_src;
  logic [4:0] i_buf_size;
  logic [5:0] i_rd_am, am_ok;
  logic [13:0] i_rate_div, d;
  logic [15:0] i_chan_en, o_sample, o_rd_data, gain, ofs, en;
  logic [63:0] i_am_en;
  logic [NCH-1:0][DW-1:0] i_adc_data;
  logic [16:0] notes[$];
  logic [15:0] stored[$];
  int error_cnt, checked, seed, n;
  bit first;

  amc_acq_ctrl #(.SETTLE_CYC(8)) amc_acq_ctrl_i (.i_clock, .i_nrst, .i_cfg_wr, .i_mode, .i_clk_src, .i_ext_rise,
    .i_pair, .i_buf_size, .i_chan_en, .i_rate_div, .i_bit_sel, .i_range_10v, .i_led_wr, .i_led_on, .i_soft_sample,
    .i_ext_clk, .i_adc_data, .o_sample, .o_bit_sel, .o_range_10v, .o_led, .o_mode, .o_cfg_err, .o_buf_full,
    .o_cal_done, .i_am_en, .i_rd_req, .i_rd_am, .o_rd_ack, .o_rd_err, .o_rd_data);
  amc_adc_model #(.POS_CODE(POS), .ZERO_CODE(ZERO)) amc_adc_model_i (.i_clock, .i_nrst, .i_sample(o_sample),
    .i_bit_sel(o_bit_sel), .o_data(i_adc_data));

  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = !i_clock;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks=%0d errors=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic do_reset;
    @(posedge i_clock);
    #1 i_nrst = 1'b0;
    repeat (6) @(posedge i_clock);
    #1 i_nrst = 1'b1;
    stored.delete();
    gain = GAIN_ONE;
    ofs = '0;
  endtask

  task automatic cfg(input logic [2:0] m, input logic [1:0] s, input logic p, input logic [15:0] e,
                     input logic [13:0] dv, input logic [2:0] b);
    @(posedge i_clock);
    #1 {i_mode, i_clk_src, i_pair, i_chan_en, i_rate_div, i_bit_sel} = {m, s, p, e, dv, b};
    i_cfg_wr = 1'b1;
    @(posedge i_clock);
    #1 i_cfg_wr = 1'b0;
    first = 1'b1;
  endtask

  task automatic wait_pulse;
    n = 0;
    do begin
      @(negedge i_clock);
      n++;
    end while (o_sample === '0 && n < 20000);
    if (n >= 20000) begin
      check(n, 0);
      complete_run();
    end
  endtask

  function automatic logic [15:0] corr(input logic [15:0] raw);
    logic signed [40:0] p;
    p = ($signed({{25{raw[15]}}, raw}) * $signed({25'h0, gain})) >>> GAIN_FRAC;
    p = p + $signed({{25{ofs[15]}}, ofs});
    if (p > 41'sd32767) return SAT_MAX;
    if (p < -41'sd32768) return SAT_MIN;
    return p[15:0];
  endfunction

  // Soft trigger; the first pulse of a run only starts a conversion
  task automatic tick;
    @(posedge i_clock);
    #1 i_soft_sample = 1'b1;
    @(posedge i_clock);
    #1 i_soft_sample = 1'b0;
    wait_pulse();
    check(o_sample, en);
    for (int ch = 0; ch < NCH; ch++) begin
      if (en[ch] && !first) stored.push_back(corr(i_adc_data[ch]));
    end
    first = 1'b0;
    repeat (1300) @(posedge i_clock);
  endtask

  task automatic read(input int cnt, input logic [5:0] am);
    @(posedge i_clock);
    #1 i_rd_am = am;
    i_rd_req = 1'b1;
    repeat (cnt) begin
      if (i_am_en[am] && stored.size() > 0) notes.push_back({1'b0, stored.pop_front()});
      else notes.push_back(17'h10000);
      @(posedge i_clock);
      #1;
    end
    i_rd_req = 1'b0;
    repeat (3) @(posedge i_clock);
  endtask

  always @(negedge i_clock) begin
    if (i_nrst && (o_rd_ack || o_rd_err) !== 1'b0) begin
      if (notes.size() == 0) check(32'h1, 32'h0);
      else check({o_rd_err, o_rd_data}, notes.pop_front());
    end
  end

  task automatic acquire;
    int g;
    int k;
    g = 1 << ($unsigned($random(seed)) % 5);
    en = '0;
    while ($countones(en) < g) en[$unsigned($random(seed)) % 16] = 1'b1;
    k = (16 / g > 4) ? 4 : 16 / g;
    cfg(MODE_CONT, SRC_SOFT, 1'b0, en, 14'h0, BIT_FIELD);
    repeat (k + 1) tick();
    read(1, ~am_ok);
    read(k * g + 1, am_ok);
    $display("acquire with %0d channels done", g);
  endtask

  task automatic rate(input logic [13:0] dv, input logic p, input int per);
    do_reset();
    en = CH_ALL;
    cfg(MODE_CONT, SRC_INT, p, en, dv, BIT_FIELD);
    wait_pulse();
    check(o_sample, p ? CH_LO : CH_ALL);
    wait_pulse();
    check(n, per);
    check(o_sample, p ? CH_HI : CH_ALL);
    $display("rate test done");
  endtask

  initial begin
    seed = 32'h0113d13d;
    {i_nrst, i_cfg_wr, i_mode, i_clk_src, i_ext_rise, i_pair, i_chan_en, i_rate_div, i_bit_sel} = '0;
    {i_range_10v, i_led_wr, i_led_on, i_soft_sample, i_ext_clk, i_rd_req, i_rd_am} = '0;
    {error_cnt, checked} = '0;
    i_buf_size = BSIZE_MAX;
    i_am_en = {$random(seed), $random(seed)};
    am_ok = 6'($random(seed));
    i_am_en[am_ok] = 1'b1;
    i_am_en[~am_ok] = 1'b0;
    do_reset();
    check({o_mode, o_led, o_range_10v, o_bit_sel, o_cal_done, o_sample}, {MODE_IDLE, 5'h18, 17'h0});
    for (int b = 0; b < 6; b++) begin
      i_range_10v = b[0];
      cfg(MODE_IDLE, SRC_SOFT, 1'b0, CH_ALL, 14'h0, 3'(b));
      check({o_bit_sel, o_range_10v}, {3'(b), b[0]});
    end
    i_soft_sample = 1'b1;
    repeat (4) @(posedge i_clock);
    #1 i_soft_sample = 1'b0;
    read(1, am_ok);
    cfg(MODE_CONT, SRC_SOFT, 1'b0, 16'h0007, 14'h0, BIT_FIELD);
    check({o_cfg_err, o_mode}, {1'b1, MODE_IDLE});
    $display("idle and selector test done");
    acquire();
    d = 14'(49 + $unsigned($random(seed)) % 200);
    rate(d, 1'b0, (int'(d) + 1) * 25);
    rate(14'h5, 1'b0, (int'(RATE_DIV_MIN) + 1) * 25);
    rate(14'h0, 1'b1, (int'(RATE_DIV_MIN_PAIR) + 1) * 25);
    do_reset();
    i_range_10v = 1'b1;
    cfg(MODE_CAL, SRC_INT, 1'b0, CH_ALL, 14'h0, BIT_FIELD);
    check(o_bit_sel, BIT_POS10);
    n = 0;
    while (o_cal_done !== 1'b1 && n < 20000) begin
      @(negedge i_clock);
      n++;
    end
    #1 check({o_cal_done, o_mode}, {1'b1, MODE_IDLE});
    if (n >= 20000) complete_run();
    gain = 16'(CAL_DIVIDEND / 33'(POS - ZERO));
    ofs = 16'(-((int'(ZERO) * int'(gain)) >>> GAIN_FRAC));
    acquire();
    @(posedge i_clock);
    #1 i_led_wr = 1'b1;
    @(posedge i_clock);
    #1 i_led_wr = 1'b0;
    check(o_led, 1'b0);
    do_reset();
    check(o_led, 1'b1);
    // Third event stalls on a full buffer until the host drains it
    i_buf_size = 5'h05;
    en = CH_ALL;
    cfg(MODE_BURST, SRC_SOFT, 1'b0, en, 14'h0, BIT_FIELD);
    repeat (3) tick();
    check(o_buf_full, 1'b0);
    read(2 * NCH + 1, am_ok);
    check(o_buf_full, 1'b1);
    cfg(MODE_TEST, SRC_EXT, 1'b0, en, 14'h0, BIT_NEG5);
    i_ext_clk = 1'b1;
    repeat (8) @(posedge i_clock);
    #1 i_ext_clk = 1'b0;
    wait_pulse();
    check({8'(n), o_sample, o_bit_sel}, {8'h05, en, BIT_NEG5});
    check(32'(notes.size()), 32'h0);
    $display("buffer test done");
    complete_run();
  end
endmodule
